// File: core/wdt_gpio_map.vh
// Overview of operation
// - index port selects data port target register
// - index upper nibble reads version, ignores writes
// - index zero write, bit0 clear, loads control
// - tick period is sixteen minus prescale seconds
// - reset bit forces reset at second timeout
// - interrupt bit raises SMI at first timeout
// - enable bit starts or stops the watchdog
// - index zero read returns status, prescale high
// - status bit 2 set after first expiry
// - status bit 3 set after second expiry
// - status bit 1 shows the enable bit, still set after the second expiry stops the count
// - period register read/write, resets all ones
// - period zero gives immediate timeout
// - bank one resets zero, outputs drive written
// - input bits ignore writes, read live pins
// - bank one direction comes from control register
// - low dir sets bits 0-4, high 5-7
`ifndef WDT_GPIO_MAP_VH
`define WDT_GPIO_MAP_VH
// host i/o ports
`define IDX_PORT 16'h0062
`define DATA_PORT 16'h0066
// index codes
`define IX_WDOG 4'h0
`define IX_PERIOD 4'h1
`define IX_BANK1 4'h2
`define IX_BANK2 4'h3
`define IX_PWM 4'h8
`define IX_PART_LO 4'h9
`define IX_VRM 4'ha
`define IX_PART_HI 4'hb
// reset values
`define INDEX_RST 4'ha
`define CTRL_RST 8'h00
`define PRESCALE_RST 4'h0
`define PERIOD_RST 8'hff
`define BANK1_RST 8'h00
`define RDATA_NONE 8'h00
// control / status field positions
`define F_KICK 0
`define F_WEN 1
`define F_SMI 2
`define F_RES 3
`define F_TO1 2
`define F_TO2 3
`define F_PRE_HI 7
`define F_PRE_LO 4
// bank one split between direction controls
`define BANK1_LOW_W 5
`define BANK1_HIGH_W 3
// timing
`define ONE_SECOND_NS 1000000000
`define CLK_PERIOD_NS 4
`define PRESCALE_BASE 5'd16
`endif

// File: core/indexed_watchdog_gpio_ctrl.v
`timescale 1ns/1ns
`include "wdt_gpio_map.vh"

// motherboard control logic behind two host i/o ports
// watchdog, bank-one gpio and index decode, all on core_clk
module indexed_watchdog_gpio_ctrl #(
  parameter [3:0] LOGIC_VERSION = 4'h0,
  parameter [31:0] SEC_CYCLES = `ONE_SECOND_NS / `CLK_PERIOD_NS
) (
  input wire core_clk,
  input wire rst_n,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata_reg,
  output reg io_rd_ack_reg,
  input wire [7:0] ext_rdata,
  output reg [3:0] ext_index_reg,
  output reg ext_wr_reg,
  output reg [7:0] ext_wdata_reg,
  input wire bank_one_low_dir,
  input wire bank_one_high_dir,
  input wire [7:0] gpio_bank_one_bits_in,
  output reg [7:0] gpio_bank_one_bits_out_reg,
  output reg [7:0] gpio_bank_one_bits_oe_reg,
  output reg smi_req_reg,
  output reg sys_reset_req_reg
);

  // port decode
  // only the two host ports are claimed, every other address is ignored
  wire idx_hit = (io_addr == `IDX_PORT);
  wire dat_hit = (io_addr == `DATA_PORT);
  wire idx_wr = io_wr & idx_hit;
  wire dat_wr = io_wr & dat_hit;
  wire dat_rd = io_rd & dat_hit;
  wire idx_rd = io_rd & idx_hit;

  // stored state
  // everything below takes its reset value on the synchronous reset
  reg [3:0] index_reg; // selected data register
  reg [3:0] prescale_reg; // prescale nibble
  reg res_en_reg; // reset on second expiry
  reg smi_en_reg; // smi on first expiry
  reg wen_reg; // watchdog enabled
  reg [7:0] period_reg; // timeout count in ticks
  reg [7:0] bank1_reg; // written bank one value
  reg first_expiry_flag_reg; // first timeout seen
  reg second_expiry_flag_reg; // second timeout seen
  reg stage_reg; // 0 waiting first, 1 waiting second
  reg [31:0] sec_cnt_reg; // cycles within a second
  reg [4:0] pre_cnt_reg; // seconds within a tick
  reg [7:0] to_cnt_reg; // ticks within a timeout

  // decoded data port writes by index
  // at index zero, bit 0 tells a control load from a kick
  wire wd_wr = dat_wr & (index_reg == `IX_WDOG);
  wire ctrl_wr = wd_wr & ~io_wdata[`F_KICK];
  wire kick_wr = wd_wr & io_wdata[`F_KICK];
  wire per_wr = dat_wr & (index_reg == `IX_PERIOD);
  wire bank1_wr = dat_wr & (index_reg == `IX_BANK1);
  // indices served by neighbouring blocks, only steered from here
  wire ext_hit = (index_reg == `IX_BANK2) | (index_reg == `IX_PWM) |
                 (index_reg == `IX_PART_LO) | (index_reg == `IX_VRM) |
                 (index_reg == `IX_PART_HI);

  // direction per bit from the port-2/control register
  // bank one holds no direction bits of its own
  wire [7:0] dir = {{`BANK1_HIGH_W{bank_one_high_dir}},
                    {`BANK1_LOW_W{bank_one_low_dir}}};

  // three-stage pin synchroniser, accepted when last two agree
  // only the second stage reads the first, which may be metastable
  reg [7:0] pin_s1_reg;
  reg [7:0] pin_s2_reg;
  reg [7:0] pin_s3_reg;
  reg [7:0] pin_live_reg; // filtered live pin levels
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      // per-bit sync and agreement filter
      always @(posedge core_clk) begin
        if (!rst_n) begin
          // pins read low until the chain has filled
          pin_s1_reg[gi] <= 1'b0;
          pin_s2_reg[gi] <= 1'b0;
          pin_s3_reg[gi] <= 1'b0;
          pin_live_reg[gi] <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= gpio_bank_one_bits_in[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          // a level counts once stages two and three agree
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_live_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // tick length: sixteen minus prescale seconds
  // one second is SEC_CYCLES clocks, one tick is tick_secs seconds
  wire [4:0] tick_secs = `PRESCALE_BASE - {1'b0, prescale_reg};
  wire restart = kick_wr | ctrl_wr; // both restart the count
  wire sec_end = (sec_cnt_reg == SEC_CYCLES - 32'd1);
  wire tick_end = sec_end & (pre_cnt_reg == tick_secs - 5'd1);
  // period compared live, so a period write acts at once
  // a zero period matches at once, which software must avoid
  wire expiry = wen_reg & ~second_expiry_flag_reg &
                (to_cnt_reg >= period_reg);
  wire expire1 = expiry & ~stage_reg;
  wire expire2 = expiry & stage_reg;

  // index register
  always @(posedge core_clk) begin
    if (!rst_n) begin
      index_reg <= `INDEX_RST;
    end else if (idx_wr) begin
      // upper nibble is the fixed version, never stored
      index_reg <= io_wdata[3:0];
    end
  end

  // control fields and period register
  always @(posedge core_clk) begin
    if (!rst_n) begin
      prescale_reg <= `PRESCALE_RST;
      res_en_reg <= 1'b0;
      smi_en_reg <= 1'b0;
      wen_reg <= 1'b0;
      period_reg <= `PERIOD_RST;
    end else begin
      // a control load also clears both flags, in the flag process
      if (ctrl_wr) begin
        // kick writes leave these untouched
        prescale_reg <= io_wdata[`F_PRE_HI:`F_PRE_LO];
        res_en_reg <= io_wdata[`F_RES];
        smi_en_reg <= io_wdata[`F_SMI];
        wen_reg <= io_wdata[`F_WEN];
      end
      // period may be rewritten at any time
      if (per_wr) begin
        period_reg <= io_wdata;
      end
    end
  end

  // prescale chain and timeout counter
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sec_cnt_reg <= 32'd0;
      pre_cnt_reg <= 5'd0;
      to_cnt_reg <= 8'd0;
      stage_reg <= 1'b0;
    end else if (restart || !wen_reg) begin
      // restart beats expiry here, but a same-cycle expiry still sets its flag and smi pulse
      // held cleared while disabled, restarted on write
      sec_cnt_reg <= 32'd0;
      pre_cnt_reg <= 5'd0;
      to_cnt_reg <= 8'd0;
      stage_reg <= 1'b0;
    end else if (expire1) begin
      // reload for a full second period
      sec_cnt_reg <= 32'd0;
      pre_cnt_reg <= 5'd0;
      to_cnt_reg <= 8'd0;
      stage_reg <= 1'b1;
    end else if (!second_expiry_flag_reg) begin
      // the chain stops after the second expiry until a control load
      if (sec_end) begin
        // end of one second
        sec_cnt_reg <= 32'd0;
        if (tick_end) begin
          // end of one tick
          pre_cnt_reg <= 5'd0;
          to_cnt_reg <= to_cnt_reg + 8'd1;
        end else begin
          pre_cnt_reg <= pre_cnt_reg + 5'd1;
        end
      end else begin
        // still inside the second
        sec_cnt_reg <= sec_cnt_reg + 32'd1;
      end
    end
  end

  // sticky expiry flags, set wins over control write clear
  always @(posedge core_clk) begin
    if (!rst_n) begin
      first_expiry_flag_reg <= 1'b0;
      second_expiry_flag_reg <= 1'b0;
    end else begin
      // an expiry in the same cycle as a control load is kept
      // a kick leaves both flags as they are
      first_expiry_flag_reg <= expire1 |
        (first_expiry_flag_reg & ~ctrl_wr);
      second_expiry_flag_reg <= expire2 |
        (second_expiry_flag_reg & ~ctrl_wr);
    end
  end

  // smi pulse and held reset request
  always @(posedge core_clk) begin
    if (!rst_n) begin
      smi_req_reg <= 1'b0;
      sys_reset_req_reg <= 1'b0;
    end else begin
      // one-cycle pulse at the first expiry only
      smi_req_reg <= expire1 & smi_en_reg;
      if (expire2 && res_en_reg) begin
        // held until the system reset clears it
        sys_reset_req_reg <= 1'b1;
      end
    end
  end

  // bank one data, writes land only on output bits
  always @(posedge core_clk) begin
    if (!rst_n) begin
      bank1_reg <= `BANK1_RST;
    end else if (bank1_wr) begin
      // input bits keep their stored value
      bank1_reg <= (io_wdata & dir) | (bank1_reg & ~dir);
    end
  end

  // pin drivers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      gpio_bank_one_bits_out_reg <= `BANK1_RST;
      // pins start released
      gpio_bank_one_bits_oe_reg <= 8'h00;
    end else begin
      gpio_bank_one_bits_out_reg <= bank1_reg;
      // enable follows the direction bits one clock later
      gpio_bank_one_bits_oe_reg <= dir;
    end
  end

  // read data mux
  reg [7:0] rdata_next;
  always @* begin
    // default answer for unmapped indices
    rdata_next = `RDATA_NONE;
    if (idx_rd) begin
      // index port read gives version and index
      rdata_next = {LOGIC_VERSION, index_reg};
    end else begin
      case (index_reg)
        `IX_WDOG: begin
          // status view
          rdata_next = {prescale_reg, second_expiry_flag_reg,
                        first_expiry_flag_reg, wen_reg, 1'b0};
        end
        `IX_PERIOD: begin
          // timeout period, read back as written
          rdata_next = period_reg;
        end
        `IX_BANK1: begin
          // output bits read stored value, input bits the pins
          rdata_next = (bank1_reg & dir) | (pin_live_reg & ~dir);
        end
        default: begin
          // indices 3 and 8 to b are served outside this block, the rest read zero
          rdata_next = ext_hit ? ext_rdata : `RDATA_NONE;
        end
      endcase
    end
  end

  // registered read answer
  always @(posedge core_clk) begin
    if (!rst_n) begin
      io_rdata_reg <= `RDATA_NONE;
      // no answer pending out of reset
      io_rd_ack_reg <= 1'b0;
    end else begin
      // acknowledge lasts one cycle, data holds to the next read
      io_rd_ack_reg <= idx_rd | dat_rd;
      if (idx_rd || dat_rd) begin
        io_rdata_reg <= rdata_next;
      end
    end
  end

  // forwarding to the externally served registers
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ext_index_reg <= `INDEX_RST;
      ext_wr_reg <= 1'b0;
      ext_wdata_reg <= 8'h00;
    end else begin
      // copy follows a same-cycle index write at once
      ext_index_reg <= idx_wr ? io_wdata[3:0] : index_reg;
      // strobe and data only for externally served indices
      ext_wr_reg <= dat_wr & ext_hit;
      if (dat_wr && ext_hit) begin
        ext_wdata_reg <= io_wdata;
      end
    end
  end

endmodule // indexed_watchdog_gpio_ctrl

// File: bench/wdt_monitor.sv
`timescale 1ns/1ns
// port-level checks of the control block
module wdt_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata_reg,
  input wire io_rd_ack_reg,
  input wire [3:0] ext_index_reg,
  input wire bank_one_low_dir,
  input wire [7:0] gpio_bank_one_bits_oe_reg,
  input wire smi_req_reg,
  input wire sys_reset_req_reg
);
  // host hit on either port
  wire hit = io_addr == 16'h0062 || io_addr == 16'h0066;
  // index nibble of a write
  wire [3:0] wr_index = io_wdata[3:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_read_acked: assert property (io_rd && hit |=> io_rd_ack_reg)
    else $error("read not acknowledged");
  a_stray_ack: assert property (io_rd && !hit |=> !io_rd_ack_reg)
    else $error("ack on foreign address");
  a_index_taken: assert property (io_wr && io_addr == 16'h0062
    |=> ext_index_reg == $past(wr_index)) else $error("index not loaded");
  a_version_zero: assert property (io_rd && io_addr == 16'h0062
    |=> io_rdata_reg[7:4] == 4'h0) else $error("version not zero");
  a_smi_pulse: assert property (smi_req_reg |=> !smi_req_reg)
    else $error("smi longer than a cycle");
  a_reset_held: assert property (sys_reset_req_reg |=> sys_reset_req_reg)
    else $error("reset request dropped");
  a_low_dir_out: assert property (bank_one_low_dir [*3]
    |-> gpio_bank_one_bits_oe_reg[4:0] == 5'h1f) else $error("low bits not driven");
  a_low_dir_in: assert property (!bank_one_low_dir [*3]
    |-> gpio_bank_one_bits_oe_reg[4:0] == 5'h00) else $error("input bits driven");
  a_off_no_smi: assert property (io_wr && io_addr == 16'h0066
    && ext_index_reg == 4'h0 && io_wdata[1:0] == 2'b00 |=> ##1 !smi_req_reg [*4])
    else $error("smi while disabled");
endmodule // wdt_monitor

bind indexed_watchdog_gpio_ctrl wdt_monitor u_mon (.core_clk, .rst_n, .io_addr, .io_wr,
  .io_rd, .io_wdata, .io_rdata_reg, .io_rd_ack_reg, .ext_index_reg, .bank_one_low_dir,
  .gpio_bank_one_bits_oe_reg, .smi_req_reg, .sys_reset_req_reg);

// File: bench/port2_model.sv
`timescale 1ns/1ns
// stand-in for the port-2 and control register block
module port2_model (
  input wire core_clk,
  input wire rst_n,
  input wire [3:0] index,
  input wire wr,
  input wire [7:0] wdata,
  output wire [7:0] rdata,
  output wire low_dir,
  output wire high_dir
);
  reg [7:0] ctrl_reg; // port-2 and control byte
  // capture writes at index 3
  always @(posedge core_clk) begin
    if (!rst_n) ctrl_reg <= 8'h00;
    else if (wr && index == 4'h3) ctrl_reg <= wdata;
  end
  // other indices answer the inverted control byte
  assign rdata = (index == 4'h3) ? ctrl_reg : ~ctrl_reg;
  assign low_dir = ctrl_reg[5];
  assign high_dir = ctrl_reg[6];
endmodule // port2_model

// File: bench/tb_top.sv
`timescale 1ns/1ns
// self-checking bench for the watchdog and gpio block
module tb_top;
  reg core_clk, rst_n, io_wr, io_rd; // bench-driven strobes
  reg [15:0] io_addr; // host address
  reg [7:0] io_wdata, pins, v; // write data, pad levels, scratch
  reg [31:0] seed; // xorshift state
  reg [7:0] exp_q[$]; // expected read data
  wire [7:0] rdata, erd, ewd, gout, goe, gin;
  wire [3:0] eidx;
  wire ack, ewr, lo, hi, smi, sysrst;
  integer fails, num_checks, smi_cnt;
  // pad level: driven bits loop back, others from bench
  assign gin = (goe & gout) | (~goe & pins);
  indexed_watchdog_gpio_ctrl #(.SEC_CYCLES(2)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata_reg(rdata), .io_rd_ack_reg(ack), .ext_rdata(erd), .ext_index_reg(eidx),
    .ext_wr_reg(ewr), .ext_wdata_reg(ewd), .bank_one_low_dir(lo), .bank_one_high_dir(hi),
    .gpio_bank_one_bits_in(gin), .gpio_bank_one_bits_out_reg(gout),
    .gpio_bank_one_bits_oe_reg(goe), .smi_req_reg(smi), .sys_reset_req_reg(sysrst));
  port2_model u_p2 (.core_clk(core_clk), .rst_n(rst_n), .index(eidx), .wr(ewr),
    .wdata(ewd), .rdata(erd), .low_dir(lo), .high_dir(hi));
  // 250 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  function automatic [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("mismatch %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  // one write, strobe for one cycle
  task wr(input [15:0] a, input [7:0] d);
    begin
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge core_clk);
      io_wr = 1'b0;
      @(negedge core_clk);
    end
  endtask
  // one read, expectation noted first
  task rd(input [15:0] a, input [7:0] e);
    begin
      if (a == 16'h0062 || a == 16'h0066) exp_q.push_back(e);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge core_clk);
      io_rd = 1'b0;
      @(negedge core_clk);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // answer watcher and smi counter
  always @(negedge core_clk) begin
    if (ack === 1'b1 && exp_q.size() == 0) chk("stray ack", 8'h00, {7'h00, ack});
    else if (ack === 1'b1) chk("read data", exp_q.pop_front(), rdata);
    if (smi === 1'b1) smi_cnt = smi_cnt + 1;
  end
  // hang guard
  initial begin
    #20000;
    fails = fails + 1;
    complete_run;
  end
  initial begin
    io_wr = 1'b0; io_rd = 1'b0; io_addr = 16'h0000; io_wdata = 8'h00;
    pins = 8'h00; rst_n = 1'b0; fails = 0; num_checks = 0; smi_cnt = 0; seed = 39;
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    rd(16'h0062, 8'h0a);
    wr(16'h0062, 8'hf1);
    wr(16'h0063, 8'h02);
    rd(16'h0063, 8'h00);
    rd(16'h0062, 8'h01);
    rd(16'h0066, 8'hff);
    repeat (4) begin
      seed = xs(seed);
      v = seed[7:0] | 8'h01;
      wr(16'h0066, v);
      rd(16'h0066, v);
    end
    wr(16'h0066, 8'h02);
    $display("test registers done");
    wr(16'h0062, 8'h03);
    wr(16'h0066, 8'h20);
    seed = xs(seed);
    pins = seed[15:8];
    v = seed[7:0];
    wr(16'h0062, 8'h02);
    wr(16'h0066, v);
    repeat (6) @(negedge core_clk);
    rd(16'h0066, {pins[7:5], v[4:0]});
    chk("gpio oe", 8'h1f, goe);
    chk("gpio out", {3'b000, v[4:0]}, gout);
    wr(16'h0062, 8'h03);
    wr(16'h0066, 8'h60);
    rd(16'h0066, 8'h60);
    wr(16'h0062, 8'h02);
    wr(16'h0066, ~v);
    repeat (6) @(negedge core_clk);
    rd(16'h0066, ~v);
    wr(16'h0062, 8'h08);
    rd(16'h0066, 8'h9f);
    wr(16'h0062, 8'h05);
    rd(16'h0066, 8'h00);
    $display("test gpio done");
    wr(16'h0062, 8'h00);
    wr(16'h0066, 8'hf6);
    repeat (8) wr(16'h0066, 8'h01);
    rd(16'h0066, 8'hf2);
    repeat (30) @(negedge core_clk);
    rd(16'h0066, 8'hfe);
    chk("smi count", 8'h01, smi_cnt[7:0]);
    chk("reset off", 8'h00, {7'h00, sysrst});
    wr(16'h0066, 8'hea);
    rd(16'h0066, 8'he2);
    repeat (8) @(negedge core_clk);
    rd(16'h0066, 8'he6);
    repeat (60) @(negedge core_clk);
    rd(16'h0066, 8'hee);
    chk("reset on", 8'h01, {7'h00, sysrst});
    chk("smi kept", 8'h01, smi_cnt[7:0]);
    wr(16'h0066, 8'h00);
    rd(16'h0066, 8'h00);
    $display("test watchdog done");
    rst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    chk("reset cleared", 8'h00, {7'h00, sysrst});
    rd(16'h0062, 8'h0a);
    repeat (4) @(negedge core_clk);
    $display("test second reset done");
    complete_run;
  end
endmodule // tb_top
